/* aphy_pkg.sv */
// Function
// R01 - Diagnostic bit 7 set holds transmit cell-available low, blocking transmit cells.
// R02 - Bit 6 clear, cell mode: receive cell-available drops after last byte of last cell.
// R03 - Bit 6 set: receive cell-available drops after payload byte 44, cell and byte modes.
// R04 - Bit 5 clear always drives receive outputs; set floats them while receive enable high.
// R05 - Software sets bit 4 to purge receive buffer; device clears it when done.
// R06 - Bit 3 set inverts bit 0 of each transmitted cell's last payload byte.
// R07 - Bit 2 set inverts bit 0 of each transmitted header check byte five.
// R08 - Bits 1:0 select loopback; 00 normal, others PHY-side or line-side loopback; code treats 11 as normal.
// R09 - Code 01 is PHY loopback, code 10 is line loopback.
// R10 - Status bit 6 clear checks received header check byte; set skips the check.
// R11 - Status bit 5 clear replaces transmitted byte five with computed header check.
// R12 - Bits 4:3 set timing marker width: 1, 2, 4 or 8 recovered clocks.
// R13 - Read-only bit 2 shows transmit buffer empty, 1 when empty; resets empty.
// R14 - Read-only bit 1 mirrors transmit activity indicator; resets to 1.
// R15 - Read-only bit 0 mirrors receive activity indicator; resets to 1.
// R16 - Low counter register returns bits 7:0 of the selected statistics counter.
// R17 - Software sets one counter select bit only; 3 symbol, 2 tx, 1 rx, 0 HEC.
// R18 - Cell-available granularity comes from master control bit 1: 0 cell, 1 byte.
// R19 - Writable diagnostic and status bits reset to zero; read-only bit writes ignored.
package aphy_pkg;

	localparam logic [7:0] APHY_ADDR_DIAG = 8'h02;
	localparam logic [7:0] APHY_ADDR_HECC = 8'h03;
	localparam logic [7:0] APHY_ADDR_CNTL = 8'h04;

	localparam int APHY_D_FORCE_TXCA = 7;
	localparam int APHY_D_EARLY_RXCA = 6;
	localparam int APHY_D_MULTI_PHY  = 5;
	localparam int APHY_D_PURGE      = 4;
	localparam int APHY_D_PAY_ERR    = 3;
	localparam int APHY_D_HEC_ERR    = 2;
	localparam int APHY_D_LOOP_HI    = 1;
	localparam int APHY_D_LOOP_LO    = 0;

	localparam int APHY_H_CHK_OFF = 6;
	localparam int APHY_H_GEN_OFF = 5;
	localparam int APHY_H_WID_HI  = 4;
	localparam int APHY_H_WID_LO  = 3;
	localparam int APHY_H_TXEMPTY = 2;
	localparam int APHY_H_TX_ACTIVITY_INDICATOR   = 1;
	localparam int APHY_H_RX_ACTIVITY_INDICATOR   = 0;

	localparam logic [7:0] APHY_DIAG_RST = 8'h00;
	localparam logic [1:0] APHY_HECC_RST = 2'h0;
	localparam logic [1:0] APHY_WID_RST  = 2'h0;
	localparam logic [7:0] APHY_RDATA_RST = 8'h00;

	localparam logic [1:0] APHY_LOOP_NORM = 2'h0;
	localparam logic [1:0] APHY_LOOP_PHY  = 2'h1;
	localparam logic [1:0] APHY_LOOP_LINE = 2'h2;

	localparam logic [5:0] APHY_IDX_HEC   = 6'h04;
	localparam logic [5:0] APHY_IDX_EARLY = 6'h31;
	localparam logic [5:0] APHY_IDX_LAST  = 6'h34;

	localparam logic [7:0] APHY_HEC_POLY  = 8'h07;
	localparam logic [7:0] APHY_HEC_COSET = 8'h55;

	localparam int APHY_MARK_MAX = 8;

endpackage : aphy_pkg

/* aphy_mark_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface aphy_mark_if;
	logic [1:0] width_code;
	modport ctrl (output width_code);
	modport gen  (input  width_code);
endinterface : aphy_mark_if
`default_nettype wire

/* aphy_mark_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module aphy_mark_gen
	import aphy_pkg::*;
(
	input  wire logic   rx_clk,
	input  wire logic   sys_rst,
	aphy_mark_if.gen    mark,
	input  wire logic   rx_marker_det,
	output logic        rx_timing_marker_out
);

	logic [1:0] wid_meta_r;
	logic [1:0] wid_sync_r;
	logic [3:0] left_r;

	// Width code is quasi-static, so a two-stage level sync is enough
	always_ff @(posedge rx_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wid_meta_r <= APHY_WID_RST;
			wid_sync_r <= APHY_WID_RST;
		end else begin
			wid_meta_r <= mark.width_code;
			wid_sync_r <= wid_meta_r;
		end
	end

	always_ff @(posedge rx_clk or posedge sys_rst) begin
		if (sys_rst) begin
			left_r               <= 4'h0;
			rx_timing_marker_out <= 1'b0;
		end else if (rx_marker_det) begin
			left_r               <= 4'((1 << wid_sync_r) - 1); // R12
			rx_timing_marker_out <= 1'b1;
		end else if (left_r != 4'h0) begin
			left_r               <= left_r - 4'h1;
			rx_timing_marker_out <= 1'b1;
		end else begin
			rx_timing_marker_out <= 1'b0;
		end
	end

endmodule : aphy_mark_gen
`default_nettype wire

/* aphy_diag_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module aphy_diag_regs
	import aphy_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       rx_clk,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       byte_mode,
	input  wire logic [7:0] counter_sel_value,
	input  wire logic       tx_buf_empty,
	input  wire logic       tx_activity_indicator,
	input  wire logic       rx_activity_indicator,
	input  wire logic       tx_clav_core,
	output logic            tx_clav,
	input  wire logic       rx_cell_ready,
	input  wire logic       rx_buf_nonempty,
	input  wire logic       rx_byte_taken,
	output logic            rx_clav,
	input  wire logic       receive_enable_in,
	input  wire logic [7:0] rx_buf_data,
	input  wire logic       rx_buf_parity,
	input  wire logic       rx_buf_soc,
	output logic      [7:0] rx_data_out,
	output logic            rx_parity_out,
	output logic            rx_soc_out,
	output logic            rx_out_oe_n,
	output logic            rx_buffer_purge,
	input  wire logic       rx_purge_done,
	input  wire logic [7:0] tx_in_byte,
	input  wire logic       tx_in_valid,
	input  wire logic       tx_in_soc,
	output logic      [7:0] line_tx_byte,
	output logic            line_tx_valid,
	output logic            line_tx_soc,
	input  wire logic [7:0] line_rx_byte,
	input  wire logic       line_rx_valid,
	input  wire logic       line_rx_soc,
	output logic      [7:0] rx_path_byte,
	output logic            rx_path_valid,
	output logic            rx_path_soc,
	output logic            rx_hec_error,
	input  wire logic       rx_marker_det,
	output logic            rx_timing_marker_out
);

	function automatic logic [7:0] aphy_crc_step(input logic [7:0] crc, input logic [7:0] d);
		logic [7:0] c;
		logic       fb;
		c  = crc;
		fb = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			fb = c[7] ^ d[i];
			c  = {c[6:0], 1'b0} ^ (fb ? APHY_HEC_POLY : 8'h00);
		end
		return c;
	endfunction : aphy_crc_step

	////////////////////////////////////////////////////////////////////////////////
	// Control registers

	logic [7:0] diag_r;
	logic       chk_off_r;
	logic       gen_off_r;
	logic [1:0] wid_r;
	logic [7:0] rdata_r;
	logic       wr_diag;
	logic       wr_hecc;
	logic [1:0] loop_sel;

	assign wr_diag  = reg_wr && (reg_addr == APHY_ADDR_DIAG);
	assign wr_hecc  = reg_wr && (reg_addr == APHY_ADDR_HECC);
	assign loop_sel = diag_r[APHY_D_LOOP_HI:APHY_D_LOOP_LO];

	// Purge bit: a software set in the same cycle as completion wins
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			diag_r <= APHY_DIAG_RST; // R19
		end else if (wr_diag) begin
			diag_r <= reg_wdata;
		end else if (rx_purge_done) begin
			diag_r[APHY_D_PURGE] <= 1'b0; // R05
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			chk_off_r <= 1'b0; // R19
			gen_off_r <= 1'b0;
			wid_r     <= APHY_HECC_RST;
		end else if (wr_hecc) begin
			chk_off_r <= reg_wdata[APHY_H_CHK_OFF];
			gen_off_r <= reg_wdata[APHY_H_GEN_OFF];
			wid_r     <= reg_wdata[APHY_H_WID_HI:APHY_H_WID_LO]; // R19
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_r <= APHY_RDATA_RST;
		end else if (reg_rd) begin
			case (reg_addr)
				APHY_ADDR_DIAG: rdata_r <= diag_r;
				APHY_ADDR_HECC: rdata_r <= {1'b0, chk_off_r, gen_off_r, wid_r,
					tx_buf_empty, tx_activity_indicator, rx_activity_indicator}; // R13 R14 R15
				APHY_ADDR_CNTL: rdata_r <= counter_sel_value; // R16
				default:        rdata_r <= 8'h00;
			endcase
		end
	end

	assign reg_rdata       = rdata_r;
	assign rx_buffer_purge = diag_r[APHY_D_PURGE]; // R05

	////////////////////////////////////////////////////////////////////////////////
	// UTOPIA cell-available and receive output drive

	logic [5:0] rx_cnt_r;
	logic       early_hold;
	logic       rx_clav_nxt;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_cnt_r <= 6'h00;
		end else if (diag_r[APHY_D_PURGE]) begin
			rx_cnt_r <= 6'h00;
		end else if (rx_byte_taken) begin
			rx_cnt_r <= (rx_cnt_r == APHY_IDX_LAST) ? 6'h00 : rx_cnt_r + 6'h01;
		end
	end

	// Past payload byte 44 with no further whole cell queued
	assign early_hold = diag_r[APHY_D_EARLY_RXCA] && (rx_cnt_r >= APHY_IDX_EARLY)
		&& !rx_cell_ready; // R03

	always_comb begin
		if (byte_mode) begin // R18
			rx_clav_nxt = rx_buf_nonempty && !early_hold; // R03
		end else begin
			rx_clav_nxt = (rx_cell_ready || (rx_cnt_r != 6'h00)) && !early_hold; // R02
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_clav       <= 1'b0;
			tx_clav       <= 1'b0;
			rx_out_oe_n   <= 1'b0;
			rx_data_out   <= 8'h00;
			rx_parity_out <= 1'b0;
			rx_soc_out    <= 1'b0;
		end else begin
			rx_clav       <= rx_clav_nxt;
			tx_clav       <= tx_clav_core && !diag_r[APHY_D_FORCE_TXCA]; // R01
			rx_out_oe_n   <= diag_r[APHY_D_MULTI_PHY] && receive_enable_in; // R04
			rx_data_out   <= rx_buf_data;
			rx_parity_out <= rx_buf_parity;
			rx_soc_out    <= rx_buf_soc;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transmit header check insertion and error injection

	logic [5:0] tx_cnt_r;
	logic [7:0] tx_crc_r;
	logic [5:0] tx_idx;
	logic [7:0] tx_crc_in;
	logic [7:0] tx_mod;

	assign tx_idx    = tx_in_soc ? 6'h00 : tx_cnt_r;
	assign tx_crc_in = tx_in_soc ? 8'h00 : tx_crc_r;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_cnt_r <= 6'h00;
			tx_crc_r <= 8'h00;
		end else if (tx_in_valid) begin
			tx_cnt_r <= (tx_idx == APHY_IDX_LAST) ? 6'h00 : tx_idx + 6'h01;
			if (tx_idx < APHY_IDX_HEC) begin
				tx_crc_r <= aphy_crc_step(tx_crc_in, tx_in_byte);
			end
		end
	end

	always_comb begin
		tx_mod = tx_in_byte;
		if (tx_idx == APHY_IDX_HEC) begin
			if (!gen_off_r) begin
				tx_mod = tx_crc_r ^ APHY_HEC_COSET; // R11
			end
			tx_mod[0] = tx_mod[0] ^ diag_r[APHY_D_HEC_ERR]; // R07
		end else if (tx_idx == APHY_IDX_LAST) begin
			tx_mod[0] = tx_mod[0] ^ diag_r[APHY_D_PAY_ERR]; // R06
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Loopback steering

	logic [7:0] tx_proc_r;
	logic       tx_proc_valid_r;
	logic       tx_proc_soc_r;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_proc_r       <= 8'h00;
			tx_proc_valid_r <= 1'b0;
			tx_proc_soc_r   <= 1'b0;
		end else begin
			tx_proc_r       <= tx_mod;
			tx_proc_valid_r <= tx_in_valid;
			tx_proc_soc_r   <= tx_in_valid && tx_in_soc;
		end
	end

	// Line loopback retransmits line bytes and keeps local cells off the wire
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			line_tx_byte  <= 8'h00;
			line_tx_valid <= 1'b0;
			line_tx_soc   <= 1'b0;
		end else if (loop_sel == APHY_LOOP_LINE) begin // R08 R09
			line_tx_byte  <= line_rx_byte;
			line_tx_valid <= line_rx_valid;
			line_tx_soc   <= line_rx_soc;
		end else begin
			line_tx_byte  <= tx_proc_r;
			line_tx_valid <= tx_proc_valid_r;
			line_tx_soc   <= tx_proc_soc_r;
		end
	end

	logic [7:0] rx_sel_byte;
	logic       rx_sel_valid;
	logic       rx_sel_soc;

	always_comb begin
		if (loop_sel == APHY_LOOP_PHY) begin // R08 R09
			rx_sel_byte  = tx_proc_r;
			rx_sel_valid = tx_proc_valid_r;
			rx_sel_soc   = tx_proc_soc_r;
		end else begin
			rx_sel_byte  = line_rx_byte;
			rx_sel_valid = line_rx_valid;
			rx_sel_soc   = line_rx_soc;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Receive header check

	logic [5:0] rc_cnt_r;
	logic [7:0] rc_crc_r;
	logic [5:0] rc_idx;
	logic [7:0] rc_crc_in;

	assign rc_idx    = rx_sel_soc ? 6'h00 : rc_cnt_r;
	assign rc_crc_in = rx_sel_soc ? 8'h00 : rc_crc_r;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rc_cnt_r      <= 6'h00;
			rc_crc_r      <= 8'h00;
			rx_hec_error  <= 1'b0;
			rx_path_byte  <= 8'h00;
			rx_path_valid <= 1'b0;
			rx_path_soc   <= 1'b0;
		end else begin
			rx_path_byte  <= rx_sel_byte;
			rx_path_valid <= rx_sel_valid;
			rx_path_soc   <= rx_sel_valid && rx_sel_soc;
			rx_hec_error  <= rx_sel_valid && (rc_idx == APHY_IDX_HEC) && !chk_off_r
				&& (rx_sel_byte != (rc_crc_r ^ APHY_HEC_COSET)); // R10
			if (rx_sel_valid) begin
				rc_cnt_r <= (rc_idx == APHY_IDX_LAST) ? 6'h00 : rc_idx + 6'h01;
				if (rc_idx < APHY_IDX_HEC) begin
					rc_crc_r <= aphy_crc_step(rc_crc_in, rx_sel_byte); // R10
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Timing marker on the recovered receive clock

	aphy_mark_if mark ();

	assign mark.width_code = wid_r; // R12

	aphy_mark_gen u_mark (
		.rx_clk               (rx_clk),
		.sys_rst              (sys_rst),
		.mark                 (mark),
		.rx_marker_det        (rx_marker_det),
		.rx_timing_marker_out (rx_timing_marker_out)
	);

endmodule : aphy_diag_regs
`default_nettype wire

/* aphy_diag_regs_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module aphy_diag_regs_asserts
	import aphy_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       sys_rst,
	input wire logic       rx_clk,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [7:0] counter_sel_value,
	input wire logic       tx_buf_empty,
	input wire logic       tx_activity_indicator,
	input wire logic       rx_activity_indicator,
	input wire logic       tx_clav_core,
	input wire logic       tx_clav,
	input wire logic       receive_enable_in,
	input wire logic [7:0] rx_buf_data,
	input wire logic [7:0] rx_data_out,
	input wire logic       rx_out_oe_n,
	input wire logic       rx_buffer_purge,
	input wire logic       rx_purge_done,
	input wire logic       rx_marker_det,
	input wire logic       rx_timing_marker_out
);
	logic [7:0] diag_s;
	logic       live_r;
	// Shadow of the diagnostic register; live_r keeps $past off reset-time values
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			diag_s <= 8'h00;
			live_r <= 1'b0;
		end else begin
			live_r <= 1'b1;
			if (reg_wr && reg_addr == APHY_ADDR_DIAG) diag_s <= reg_wdata;
			else if (rx_purge_done) diag_s[4] <= 1'b0;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	sequence s_purge_req; reg_wr && reg_addr == APHY_ADDR_DIAG && reg_wdata[4]; endsequence
	sequence s_purge_up; ##[1:2] rx_buffer_purge; endsequence
	property p_purge_set; s_purge_req |-> s_purge_up; endproperty
	property p_purge_clr; rx_purge_done && !reg_wr |-> ##[1:2] !rx_buffer_purge; endproperty
	property p_txclav; live_r |-> tx_clav == ($past(tx_clav_core) & ~$past(diag_s[7])); endproperty
	property p_oe; live_r |-> rx_out_oe_n == ($past(diag_s[5]) & $past(receive_enable_in)); endproperty
	property p_rx_copy; live_r |-> rx_data_out == $past(rx_buf_data); endproperty
	property p_rd_cnt; reg_rd && reg_addr == APHY_ADDR_CNTL |=> reg_rdata == $past(counter_sel_value); endproperty
	property p_rd_unm; reg_rd && (reg_addr < 8'h02 || reg_addr > 8'h04) |=> reg_rdata == 8'h00; endproperty
	property p_rd_st;
		reg_rd && reg_addr == APHY_ADDR_HECC |=> !reg_rdata[7]
			&& reg_rdata[2:0] == {$past(tx_buf_empty), $past(tx_activity_indicator), $past(rx_activity_indicator)};
	endproperty
	property p_marker;
		@(posedge rx_clk) disable iff (sys_rst) rx_marker_det |-> ##[1:2] rx_timing_marker_out;
	endproperty
	a_purge_set: assert property (p_purge_set) else $error("purge not raised");
	a_purge_clr: assert property (p_purge_clr) else $error("purge not cleared");
	a_txclav: assert property (p_txclav) else $error("tx cell-available wrong");
	a_oe: assert property (p_oe) else $error("receive drive enable wrong");
	a_rx_copy: assert property (p_rx_copy) else $error("receive data not passed");
	a_rd_cnt: assert property (p_rd_cnt) else $error("counter byte wrong");
	a_rd_unm: assert property (p_rd_unm) else $error("unmapped read not zero");
	a_rd_st: assert property (p_rd_st) else $error("status bits wrong");
	a_marker: assert property (p_marker) else $error("marker missing");
endmodule : aphy_diag_regs_asserts
bind aphy_diag_regs aphy_diag_regs_asserts i_aphy_diag_regs_asserts (.sys_clk, .sys_rst, .rx_clk, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .counter_sel_value, .tx_buf_empty, .tx_activity_indicator,
	.rx_activity_indicator, .tx_clav_core, .tx_clav, .receive_enable_in, .rx_buf_data, .rx_data_out,
	.rx_out_oe_n, .rx_buffer_purge, .rx_purge_done, .rx_marker_det, .rx_timing_marker_out);
`default_nettype wire

/* aphy_atm_model.sv */
`timescale 1ns/1ps
`default_nettype none
module aphy_atm_model (
	input  wire logic       sys_clk,
	output logic      [7:0] tx_in_byte,
	output logic            tx_in_valid,
	output logic            tx_in_soc
);
	initial begin
		tx_in_byte = 8'hA5;
		tx_in_valid = 1'b0;
		tx_in_soc = 1'b0;
	end
	// Byte i carries value i; idle data inverts so stale bytes never look valid
	task automatic send_cell(input bit gap);
		for (int i = 0; i < 53; i++) begin
			@(posedge sys_clk);
			#1;
			tx_in_byte = 8'(i);
			tx_in_valid = 1'b1;
			tx_in_soc = (i == 0);
			if (gap) begin
				@(posedge sys_clk);
				#1;
				tx_in_valid = 1'b0;
				tx_in_soc = 1'b0;
				tx_in_byte = ~tx_in_byte;
			end
		end
		@(posedge sys_clk);
		#1;
		tx_in_valid = 1'b0;
		tx_in_soc = 1'b0;
		tx_in_byte = ~tx_in_byte;
	endtask : send_cell
endmodule : aphy_atm_model
`default_nettype wire

/* aphy_diag_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module aphy_diag_regs_tb_top
	import aphy_pkg::*;
;
	logic sys_clk, sys_rst, rx_clk, reg_wr, reg_rd, byte_mode, tx_buf_empty, tx_clav_core, tx_clav, rx_clav;
	logic tx_activity_indicator, rx_activity_indicator, rx_buf_nonempty, receive_enable_in, rx_out_oe_n;
	logic rx_buffer_purge, rx_purge_done, tx_in_valid, tx_in_soc, line_tx_valid, line_tx_soc, line_rx_valid;
	logic rx_marker_det, rx_timing_marker_out;
	logic rx_cell_ready, rx_byte_taken, rx_path_valid, rx_hec_error, hec_seen;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, counter_sel_value, rx_buf_data, tx_in_byte, line_tx_byte;
	logic [7:0] line_rx_byte;
	logic [7:0] cap [0:52];
	int cap_i, err_count, cmp_count;
	aphy_diag_regs i_aphy_diag_regs (.sys_clk, .sys_rst, .rx_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .byte_mode, .counter_sel_value, .tx_buf_empty, .tx_activity_indicator, .rx_activity_indicator,
		.tx_clav_core, .tx_clav, .rx_cell_ready, .rx_buf_nonempty, .rx_byte_taken, .rx_clav,
		.receive_enable_in, .rx_buf_data, .rx_buf_parity(1'b0), .rx_buf_soc(1'b0), .rx_data_out(),
		.rx_parity_out(), .rx_soc_out(), .rx_out_oe_n, .rx_buffer_purge, .rx_purge_done, .tx_in_byte,
		.tx_in_valid, .tx_in_soc, .line_tx_byte, .line_tx_valid, .line_tx_soc, .line_rx_byte, .line_rx_valid,
		.line_rx_soc(1'b0), .rx_path_byte(), .rx_path_valid, .rx_path_soc(), .rx_hec_error, .rx_marker_det,
		.rx_timing_marker_out);
	aphy_atm_model i_aphy_atm_model (.sys_clk, .tx_in_byte, .tx_in_valid, .tx_in_soc);
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Link clock phase offset on purpose
	initial begin
		rx_clk = 1'b0;
		#7;
		forever #24 rx_clk = ~rx_clk;
	end
	always @(posedge sys_clk) begin
		if (line_tx_valid) begin
			if (line_tx_soc) cap_i = 0;
			if (cap_i < 53) cap[cap_i] = line_tx_byte;
			cap_i++;
		end
	end
	// Cleared at each local cell start so stale line-path errors do not count
	always @(posedge sys_clk) begin
		if (tx_in_valid && tx_in_soc) hec_seen = 1'b0;
		if (rx_hec_error) hec_seen = 1'b1;
	end
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		cyc(1);
		reg_wr = 1'b0;
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		reg_addr = a;
		reg_rd = 1'b1;
		cyc(1);
		reg_rd = 1'b0;
		cyc(1);
		chk(reg_rdata, exp);
	endtask : rd_chk
	task automatic t_regs;
		rd_chk(APHY_ADDR_DIAG, 8'h00);
		rd_chk(APHY_ADDR_HECC, 8'h07);
		rd_chk(APHY_ADDR_CNTL, 8'h00);
		counter_sel_value = 8'h5A;
		rd_chk(APHY_ADDR_CNTL, 8'h5A);
		rd_chk(8'h05, 8'h00);
		wr(APHY_ADDR_HECC, 8'hFF);
		{tx_buf_empty, tx_activity_indicator, rx_activity_indicator} = 3'h0;
		rd_chk(APHY_ADDR_HECC, 8'h78);
		wr(APHY_ADDR_HECC, 8'h00);
	endtask : t_regs
	task automatic t_clav;
		tx_clav_core = 1'b1;
		wr(APHY_ADDR_DIAG, 8'h80);
		cyc(2);
		chk({7'h00, tx_clav}, 8'h00);
		wr(APHY_ADDR_DIAG, 8'h00);
		cyc(2);
		chk({7'h00, tx_clav}, 8'h01);
		rx_buf_nonempty = 1'b1;
		byte_mode = 1'b1;
		cyc(2);
		chk({7'h00, rx_clav}, 8'h01);
		byte_mode = 1'b0;
		cyc(2);
		chk({7'h00, rx_clav}, 8'h00);
		rx_cell_ready = 1'b1;
		cyc(2);
		chk({7'h00, rx_clav}, 8'h01);
		rx_cell_ready = 1'b0;
		byte_mode = 1'b1;
		wr(APHY_ADDR_DIAG, 8'h40);
		rx_byte_taken = 1'b1;
		cyc(48);
		rx_byte_taken = 1'b0;
		cyc(2);
		chk({7'h00, rx_clav}, 8'h01);
		rx_byte_taken = 1'b1;
		cyc(1);
		rx_byte_taken = 1'b0;
		cyc(2);
		chk({7'h00, rx_clav}, 8'h00);
		byte_mode = 1'b0;
		wr(APHY_ADDR_DIAG, 8'h00);
	endtask : t_clav
	task automatic t_loop;
		wr(APHY_ADDR_DIAG, 8'h02);
		cyc(3);
		chk(line_tx_byte, 8'h96);
		chk({7'h00, line_tx_valid}, 8'h01);
		wr(APHY_ADDR_DIAG, 8'h01);
		cyc(2);
		chk({7'h00, rx_path_valid}, 8'h00);
		wr(APHY_ADDR_DIAG, 8'h00);
		cyc(2);
		chk({7'h00, rx_path_valid}, 8'h01);
	endtask : t_loop
	task automatic t_purge_oe;
		wr(APHY_ADDR_DIAG, 8'h10);
		cyc(2);
		chk({7'h00, rx_buffer_purge}, 8'h01);
		rx_purge_done = 1'b1;
		cyc(1);
		rx_purge_done = 1'b0;
		rd_chk(APHY_ADDR_DIAG, 8'h00);
		wr(APHY_ADDR_DIAG, 8'h20);
		rx_buf_data = 8'h3C;
		cyc(2);
		chk({7'h00, rx_out_oe_n}, 8'h01);
		receive_enable_in = 1'b0;
		cyc(2);
		chk({7'h00, rx_out_oe_n}, 8'h00);
		receive_enable_in = 1'b1;
		wr(APHY_ADDR_DIAG, 8'h00);
		cyc(2);
		chk({7'h00, rx_out_oe_n}, 8'h00);
	endtask : t_purge_oe
	task automatic t_tx(input logic [7:0] d, input logic [7:0] h, input logic [7:0] e4, input logic [7:0] e52);
		wr(APHY_ADDR_DIAG, d);
		wr(APHY_ADDR_HECC, h);
		i_aphy_atm_model.send_cell(h[5]);
		cyc(4);
		chk(cap[0], 8'h00);
		chk(cap[4], e4);
		chk(cap[52], e52);
	endtask : t_tx
	task automatic t_marker;
		int n;
		for (int w = 0; w < 4; w++) begin
			wr(APHY_ADDR_HECC, 8'(w << 3));
			repeat (4) @(posedge rx_clk);
			#1;
			rx_marker_det = 1'b1;
			n = 0;
			repeat (12) begin
				@(posedge rx_clk);
				#1;
				rx_marker_det = 1'b0;
				n += int'(rx_timing_marker_out);
			end
			chk(8'(n), 8'(1 << w));
		end
	endtask : t_marker
	initial begin
		logic [7:0] c;
		{reg_wr, reg_rd, byte_mode, tx_clav_core, rx_buf_nonempty, rx_purge_done, rx_marker_det} = 7'h00;
		{rx_cell_ready, rx_byte_taken, hec_seen} = 3'h0;
		{tx_buf_empty, tx_activity_indicator, rx_activity_indicator, receive_enable_in} = 4'hF;
		{reg_addr, reg_wdata, counter_sel_value} = 24'h000000;
		{rx_buf_data, line_rx_byte, line_rx_valid} = {8'hC3, 8'h96, 1'b1};
		{err_count, cmp_count, cap_i} = '0;
		sys_rst = 1'b1;
		cyc(12);
		sys_rst = 1'b0;
		cyc(1);
		t_regs();
		t_clav();
		t_purge_oe();
		c = 8'h00;
		for (int i = 0; i < 4; i++) begin
			c ^= 8'(i);
			for (int k = 0; k < 8; k++) c = c[7] ? {c[6:0], 1'b0} ^ APHY_HEC_POLY : {c[6:0], 1'b0};
		end
		t_tx(8'h0C, 8'h00, c ^ 8'h55 ^ 8'h01, 8'h35);
		t_tx(8'h00, 8'h20, 8'h04, 8'h34);
		t_tx(8'h05, 8'h00, c ^ 8'h55 ^ 8'h01, 8'h34);
		chk({7'h00, hec_seen}, 8'h01);
		t_loop();
		t_marker();
		complete_run();
	end
	initial begin
		#300000;
		err_count++;
		complete_run();
	end
endmodule : aphy_diag_regs_tb_top
`default_nettype wire
